// ### ibc_pkg.sv
// Overview of operation
// - transfers are whole bytes, shifted most significant bit first.
// - each unit is nine clocks: eight data bits then one acknowledge bit.
// - after the eighth falling clock the sender releases data, samples ack.
// - master makes the clock; data changes while low, sampled on rise.
// - with module enabled, both pins act as open-drain only.
// - pin output value is fixed at zero; pins only pull low or release.
// - hold select keeps data valid at least 300 ns after clock falls.
// - start is data falling while clock high; bus becomes active.
// - generating a start with data already low flags a bus collision.
// - stop is data rising while clock high.
// - stop counts only after one clock low period followed the start.
// - repeated start is accepted wherever a stop would be valid.
// - repeated start resets slave logic and expects an address byte.
// - ten-bit read needs restart plus high byte with read bit set.
// - ten-bit full write match sets prior-match until stop or mismatch.
// - start and stop interrupt enables raise events in plain slave modes.
// - in start/stop reporting modes those enables change nothing.
// - data sampled low while driving an expected high is a collision.
// - bus idle only with no master and both lines high.
// - any party may hold clock low; clock source waits for release.
// - after a read address the slave supplies bytes until a byte is not acknowledged, or restart/stop.
// - ten-bit first byte matches 11110, two upper bits, then zero.
// - direction bit one means master reads, zero means master writes.
package ibc_pkg;

  localparam int CLK_MHZ        = 40;
  localparam int HOLD_LONG_NS   = 300;
  localparam int HOLD_SHORT_NS  = 100;
  localparam int HOLD_LONG_CYC  = (HOLD_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] HOLD_LONG  = 4'(HOLD_LONG_CYC);
  localparam logic [3:0] HOLD_SHORT = 4'(HOLD_SHORT_CYC);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int MODE_TEN_BIT = 0;
  localparam int MODE_SP_IRQ  = 1;

  typedef enum logic [1:0] {
    MODE_S7    = 2'b00,
    MODE_S10   = 2'b01,
    MODE_S7_SP = 2'b10,
    MODE_S10_SP = 2'b11
  } ibc_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDR_LO = 3'b010,
    ST_RX      = 3'b011,
    ST_TX      = 3'b100,
    ST_IGNORE  = 3'b101
  } ibc_state_e;

  typedef struct packed {
    logic       serial_port_enable;
    ibc_mode_e  mode;
    logic       data_hold_select;
    logic       start_irq_enable;
    logic       stop_irq_enable;
    logic [9:0] slave_address_reg;
  } ibc_ctrl_s;

  typedef struct packed {
    logic bus_idle;
    logic addressed;
    logic read_mode;
    logic prior_match;
  } ibc_stat_s;

  typedef struct packed {
    logic req;
    logic now;
    logic low;
  } ibc_drv_s;

  localparam ibc_drv_s DRV_NONE     = 3'b000;
  localparam ibc_drv_s DRV_HOLD_REL = 3'b100;
  localparam ibc_drv_s DRV_HOLD_LOW = 3'b101;
  localparam ibc_drv_s DRV_NOW_REL  = 3'b110;
  localparam ibc_drv_s DRV_NOW_LOW  = 3'b111;

endpackage : ibc_pkg

// ### ibc_core.sv
`timescale 1ns/1ps
module ibc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0]  wr_ff;
  logic [AW:0]  rd_ff;

  assign in_ready  = !((wr_ff[AW] != rd_ff[AW]) &&
                       (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
  assign out_valid = (wr_ff != rd_ff);
  assign out_data  = mem_ff[rd_ff[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end

endmodule : ibc_fifo

module ibc_core (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // bus pins
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  // control
  input  wire ibc_pkg::ibc_ctrl_s ctrl,
  input  wire logic              start_request,
  // status and events
  output ibc_pkg::ibc_stat_s     stat,
  output logic                   start_seen,
  output logic                   stop_seen,
  output logic                   cond_irq,
  output logic                   bus_collision,
  // received data
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic [7:0]             rx_data,
  // transmit data
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [7:0]        tx_data
);

  logic                scl_meta_ff;
  logic                scl_sync_ff;
  logic                sda_meta_ff;
  logic                sda_sync_ff;
  logic                scl_prev_ff;
  logic                sda_prev_ff;
  ibc_pkg::ibc_state_e state_ff;
  logic [3:0]          bit_cnt_ff;
  logic                ack_phase_ff;
  logic [7:0]          rx_sr_ff;
  logic [7:0]          tx_sr_ff;
  logic                rw_ff;
  logic                prior_ff;
  logic                tx_go_ff;
  logic                acked_ff;
  logic                wait_push_ff;
  logic                wait_tx_ff;
  logic                scl_hold_ff;
  ibc_pkg::ibc_drv_s   drv_ff;
  logic                sda_drv_ff;
  logic [3:0]          hold_cnt_ff;
  logic                hold_low_ff;
  logic                active_ff;
  logic                low_seen_ff;
  logic                idle_ff;
  logic                start_seen_ff;
  logic                stop_seen_ff;
  logic                cond_irq_ff;
  logic                bcol_ff;
  logic                gen_ff;
  logic [4:0]          since_fall_ff;
  logic                en;
  logic                sp_mode;
  logic                ten_bit;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_det;
  logic                stop_det;
  logic                busy;
  logic                in_tx;
  logic                byte_done;
  logic                ack_done;
  logic                coll_tx;
  logic                start_ok;
  logic                load_tx;
  logic                fifo_in_valid;
  logic                fifo_in_ready;
  logic                drv_now;
  logic [3:0]          hold_cyc;

  // input synchronisers and edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_i;
      scl_sync_ff <= scl_meta_ff;
      sda_meta_ff <= sda_i;
      sda_sync_ff <= sda_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  // bus events
  assign en        = ctrl.serial_port_enable;
  assign sp_mode   = ctrl.mode[ibc_pkg::MODE_SP_IRQ];
  assign ten_bit   = ctrl.mode[ibc_pkg::MODE_TEN_BIT];
  assign scl_rise  = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall  = ~scl_sync_ff & scl_prev_ff;
  assign start_det = en & scl_sync_ff & scl_prev_ff &
                     sda_prev_ff & ~sda_sync_ff;
  assign stop_det  = en & scl_sync_ff & scl_prev_ff & ~sda_prev_ff &
                     sda_sync_ff & low_seen_ff;
  assign busy      = (state_ff != ibc_pkg::ST_IDLE) &&
                     (state_ff != ibc_pkg::ST_IGNORE);
  assign in_tx     = (state_ff == ibc_pkg::ST_TX);
  assign byte_done = scl_fall & busy & ~ack_phase_ff &
                     (bit_cnt_ff == ibc_pkg::BITS_PER_BYTE);
  assign ack_done  = scl_fall & busy & ack_phase_ff;
  assign coll_tx   = in_tx & scl_rise & ~ack_phase_ff & tx_sr_ff[7] &
                     (bit_cnt_ff < ibc_pkg::BITS_PER_BYTE) &
                     ~sda_sync_ff;
  assign start_ok  = en & start_request & ~gen_ff & ~active_ff;
  assign load_tx   = ack_done & in_tx & (tx_go_ff | acked_ff);
  assign tx_ready  = en & ~start_det & ~stop_det & ~coll_tx &
                     (load_tx | wait_tx_ff);
  assign fifo_in_valid = en & ~start_det & ~stop_det &
                         ((byte_done & (state_ff == ibc_pkg::ST_RX)) |
                          wait_push_ff);
  assign drv_now   = drv_ff.now;
  assign hold_cyc  = ctrl.data_hold_select ? ibc_pkg::HOLD_LONG
                                           : ibc_pkg::HOLD_SHORT;

  // pins: open drain, value always zero
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = en & scl_hold_ff;
  assign sda_oe = en & (sda_drv_ff | gen_ff);

  assign stat.bus_idle    = idle_ff;
  assign stat.addressed   = busy & (state_ff != ibc_pkg::ST_ADDR);
  assign stat.read_mode   = rw_ff;
  assign stat.prior_match = prior_ff;
  assign start_seen       = start_seen_ff;
  assign stop_seen        = stop_seen_ff;
  assign cond_irq         = cond_irq_ff;
  assign bus_collision    = bcol_ff;

  // byte engine and slave state machine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff     <= ibc_pkg::ST_IDLE;
      bit_cnt_ff   <= 4'h0;
      ack_phase_ff <= 1'b0;
      rx_sr_ff     <= 8'h00;
      tx_sr_ff     <= 8'h00;
      rw_ff        <= 1'b0;
      prior_ff     <= 1'b0;
      tx_go_ff     <= 1'b0;
      acked_ff     <= 1'b0;
      wait_push_ff <= 1'b0;
      wait_tx_ff   <= 1'b0;
      scl_hold_ff  <= 1'b0;
      drv_ff       <= ibc_pkg::DRV_NONE;
    end else begin
      drv_ff <= ibc_pkg::DRV_NONE;
      if (!en || start_det || stop_det) begin
        state_ff     <= start_det ? ibc_pkg::ST_ADDR
                                  : ibc_pkg::ST_IDLE;
        bit_cnt_ff   <= 4'h0;
        ack_phase_ff <= 1'b0;
        tx_go_ff     <= 1'b0;
        wait_push_ff <= 1'b0;
        wait_tx_ff   <= 1'b0;
        scl_hold_ff  <= 1'b0;
        drv_ff       <= ibc_pkg::DRV_NOW_REL;
        if (!start_det) begin
          prior_ff <= 1'b0;
        end
      end else if (coll_tx) begin
        state_ff <= ibc_pkg::ST_IGNORE;
        drv_ff   <= ibc_pkg::DRV_NOW_REL;
      end else begin
        if (scl_rise && busy && !ack_phase_ff &&
            bit_cnt_ff < ibc_pkg::BITS_PER_BYTE) begin
          rx_sr_ff   <= {rx_sr_ff[6:0], sda_sync_ff};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
        if (scl_rise && ack_phase_ff && in_tx) begin
          acked_ff <= ~sda_sync_ff;
        end
        if (scl_fall && in_tx && !ack_phase_ff && bit_cnt_ff != 4'h0 &&
            bit_cnt_ff < ibc_pkg::BITS_PER_BYTE) begin
          tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
          drv_ff   <= tx_sr_ff[6] ? ibc_pkg::DRV_HOLD_REL
                                  : ibc_pkg::DRV_HOLD_LOW;
        end
        if (byte_done) begin
          ack_phase_ff <= 1'b1;
          case (state_ff)
            ibc_pkg::ST_ADDR: begin
              if (ten_bit) begin
                if (rx_sr_ff[7:3] == ibc_pkg::TEN_BIT_PREFIX &&
                    rx_sr_ff[2:1] == ctrl.slave_address_reg[9:8]) begin
                  if (!rx_sr_ff[0]) begin
                    prior_ff <= 1'b0;
                    state_ff <= ibc_pkg::ST_ADDR_LO;
                    drv_ff   <= ibc_pkg::DRV_HOLD_LOW;
                  end else if (prior_ff) begin
                    rw_ff    <= 1'b1;
                    tx_go_ff <= 1'b1;
                    state_ff <= ibc_pkg::ST_TX;
                    drv_ff   <= ibc_pkg::DRV_HOLD_LOW;
                  end else begin
                    state_ff <= ibc_pkg::ST_IGNORE;
                  end
                end else begin
                  prior_ff <= 1'b0;
                  state_ff <= ibc_pkg::ST_IGNORE;
                end
              end else if (rx_sr_ff[7:1] ==
                           ctrl.slave_address_reg[6:0]) begin
                rw_ff    <= rx_sr_ff[0];
                tx_go_ff <= rx_sr_ff[0];
                state_ff <= rx_sr_ff[0] ? ibc_pkg::ST_TX
                                        : ibc_pkg::ST_RX;
                drv_ff   <= ibc_pkg::DRV_HOLD_LOW;
              end else begin
                state_ff <= ibc_pkg::ST_IGNORE;
              end
            end
            ibc_pkg::ST_ADDR_LO: begin
              if (rx_sr_ff == ctrl.slave_address_reg[7:0]) begin
                prior_ff <= 1'b1;
                rw_ff    <= 1'b0;
                state_ff <= ibc_pkg::ST_RX;
                drv_ff   <= ibc_pkg::DRV_HOLD_LOW;
              end else begin
                state_ff <= ibc_pkg::ST_IGNORE;
              end
            end
            ibc_pkg::ST_RX: begin
              if (fifo_in_ready) begin
                drv_ff <= ibc_pkg::DRV_HOLD_LOW;
              end else begin
                wait_push_ff <= 1'b1;
                scl_hold_ff  <= 1'b1;
              end
            end
            ibc_pkg::ST_TX: begin
              drv_ff <= ibc_pkg::DRV_HOLD_REL;
            end
            default: begin
              state_ff <= ibc_pkg::ST_IGNORE;
            end
          endcase
        end
        if (ack_done) begin
          ack_phase_ff <= 1'b0;
          bit_cnt_ff   <= 4'h0;
          tx_go_ff     <= 1'b0;
          drv_ff       <= ibc_pkg::DRV_HOLD_REL;
          if (in_tx && !(tx_go_ff || acked_ff)) begin
            state_ff <= ibc_pkg::ST_IGNORE;
          end else if (load_tx) begin
            if (tx_valid) begin
              tx_sr_ff <= tx_data;
              drv_ff   <= tx_data[7] ? ibc_pkg::DRV_HOLD_REL
                                     : ibc_pkg::DRV_HOLD_LOW;
            end else begin
              wait_tx_ff  <= 1'b1;
              scl_hold_ff <= 1'b1;
            end
          end
        end
        if (wait_tx_ff && tx_valid) begin
          tx_sr_ff    <= tx_data;
          drv_ff      <= tx_data[7] ? ibc_pkg::DRV_NOW_REL
                                    : ibc_pkg::DRV_NOW_LOW;
          wait_tx_ff  <= 1'b0;
          scl_hold_ff <= 1'b0;
        end
        if (wait_push_ff && fifo_in_ready) begin
          drv_ff       <= ibc_pkg::DRV_NOW_LOW;
          wait_push_ff <= 1'b0;
          scl_hold_ff  <= 1'b0;
        end
      end
    end
  end

  // data line drive with selectable hold
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_drv_ff  <= 1'b0;
      hold_cnt_ff <= 4'h0;
      hold_low_ff <= 1'b0;
    end else if (!en) begin
      sda_drv_ff  <= 1'b0;
      hold_cnt_ff <= 4'h0;
    end else if (drv_ff.req) begin
      if (drv_ff.now) begin
        sda_drv_ff  <= drv_ff.low;
        hold_cnt_ff <= 4'h0;
      end else begin
        hold_cnt_ff <= hold_cyc;
        hold_low_ff <= drv_ff.low;
      end
    end else if (hold_cnt_ff != 4'h0) begin
      hold_cnt_ff <= hold_cnt_ff - 4'h1;
      if (hold_cnt_ff == 4'h1) begin
        sda_drv_ff <= hold_low_ff;
      end
    end
  end

  // bus state and condition events
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_ff     <= 1'b0;
      low_seen_ff   <= 1'b0;
      idle_ff       <= 1'b1;
      start_seen_ff <= 1'b0;
      stop_seen_ff  <= 1'b0;
      cond_irq_ff   <= 1'b0;
    end else begin
      start_seen_ff <= start_det;
      stop_seen_ff  <= stop_det;
      cond_irq_ff   <= (start_det & (sp_mode | ctrl.start_irq_enable)) |
                       (stop_det & (sp_mode | ctrl.stop_irq_enable));
      idle_ff <= ~active_ff & scl_sync_ff & sda_sync_ff;
      if (!en || stop_det) begin
        active_ff   <= 1'b0;
        low_seen_ff <= 1'b0;
      end else if (start_det) begin
        active_ff   <= 1'b1;
        low_seen_ff <= 1'b0;
      end else if (scl_fall && active_ff) begin
        low_seen_ff <= 1'b1;
      end
    end
  end

  // start generation and collision
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gen_ff  <= 1'b0;
      bcol_ff <= 1'b0;
    end else begin
      bcol_ff <= coll_tx | (start_ok & ~sda_sync_ff);
      if (!en || scl_fall) begin
        gen_ff <= 1'b0;
      end else if (start_ok && sda_sync_ff) begin
        gen_ff <= 1'b1;
      end
    end
  end

  // received bytes buffer
  ibc_fifo #(
    .W     (ibc_pkg::DATA_W),
    .DEPTH (ibc_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_sr_ff),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // cycles since the last clock fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_fall_ff <= 5'h1f;
    end else if (scl_fall) begin
      since_fall_ff <= 5'h00;
    end else if (since_fall_ff != 5'h1f) begin
      since_fall_ff <= since_fall_ff + 5'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence tx_byte_end;
    byte_done && in_tx;
  endsequence

  a_oe_disabled: assert property (
    !en |=> !sda_oe && !scl_oe)
    else $error("pins driven while disabled");
  a_msb_first: assert property (
    scl_rise && busy && !ack_phase_ff && bit_cnt_ff < 4'h8 && en &&
    !start_det && !stop_det && !coll_tx
    |=> rx_sr_ff[0] == $past(sda_sync_ff))
    else $error("bit not shifted in at lsb");
  a_ack_release: assert property (
    (tx_byte_end and !stop_det) |-> ##[1:16] !sda_drv_ff)
    else $error("data not released after eighth bit");
  a_hold_time: assert property (
    en && $changed(sda_drv_ff) && !scl_sync_ff && !$past(drv_now)
    |-> since_fall_ff >= (ctrl.data_hold_select ? ibc_pkg::HOLD_LONG
                                                 : ibc_pkg::HOLD_SHORT))
    else $error("data hold too short");
  a_start_coll: assert property (
    start_ok && !sda_sync_ff |=> bus_collision && !gen_ff)
    else $error("start collision missed");
  a_stop_valid: assert property (
    stop_seen_ff |-> $past(low_seen_ff))
    else $error("stop without clock low");
  a_restart_addr: assert property (
    start_det |=> state_ff == ibc_pkg::ST_ADDR && bit_cnt_ff == 4'h0)
    else $error("slave logic not reset by start");
  a_prior_clear: assert property (
    stop_det |=> !prior_ff)
    else $error("prior match kept after stop");
  a_irq_masked: assert property (
    start_det && !sp_mode && !ctrl.start_irq_enable
    && !stop_det |=> !cond_irq)
    else $error("masked start raised event");
  a_irq_sp_mode: assert property (
    (start_det || stop_det) && sp_mode |=> cond_irq)
    else $error("condition event missing");
  a_tx_coll: assert property (
    coll_tx |=> bus_collision && state_ff == ibc_pkg::ST_IGNORE)
    else $error("transmit collision missed");
  a_idle_lines: assert property (
    stat.bus_idle |-> $past(scl_sync_ff) && $past(sda_sync_ff))
    else $error("idle with a line low");
  a_stretch_hold: assert property (
    en && (wait_push_ff || wait_tx_ff) |-> scl_oe)
    else $error("clock not held while waiting");

endmodule : ibc_core

// ### ibc_master_model.sv
`timescale 1ns/1ps
module ibc_master_model (
  // clock
  input  wire logic clk,
  // bus levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // pulls, high drives the line low
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // data set while clock low, sampled while high
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    wt(20);
    scl_low = 1'b0;
    for (int i = 0; i < 400 && !scl_in; i++) @(negedge clk);
    wt(4);
    r = sda_in;
    scl_low = 1'b1;
    wt(4);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
  endtask : byte_io

  // waits out the slave's acknowledge hold before raising the clock
  task automatic start;
    sda_low = 1'b0;
    wt(20);
    scl_low = 1'b0;
    wt(8);
    sda_low = 1'b1;
    wt(8);
    scl_low = 1'b1;
    wt(4);
  endtask : start

  task automatic stop;
    sda_low = 1'b1;
    wt(8);
    scl_low = 1'b0;
    wt(8);
    sda_low = 1'b0;
    wt(8);
  endtask : stop
endmodule : ibc_master_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic               clk, nrst, start_request, rx_ready, tx_valid;
  logic               scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda;
  logic               start_seen, stop_seen, cond_irq, bus_collision;
  logic               rx_valid, tx_ready, a, oe_q, scl_q;
  logic [7:0]         rx_data, tx_data, q, d;
  logic [9:0]         adr;
  logic [7:0]         exp_q[$];
  ibc_pkg::ibc_ctrl_s ctrl;
  ibc_pkg::ibc_stat_s stat;
  int                 n_fail, checks_done, n_st, n_sp, n_irq, n_col;
  int                 fc, cyc, irq0;
  int                 hmin[2] = '{99, 99};
  wire                scl_w = ~(scl_oe | m_scl);
  wire                sda_w = ~(sda_oe | m_sda);

  ibc_core dut (.clk(clk), .nrst(nrst), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .ctrl(ctrl), .start_request(start_request), .stat(stat),
    .start_seen(start_seen), .stop_seen(stop_seen), .cond_irq(cond_irq),
    .bus_collision(bus_collision), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data));
  ibc_master_model m (.clk(clk), .scl_in(scl_w), .sda_in(sda_w),
    .scl_low(m_scl), .sda_low(m_sda));

  always #12.5 clk = ~clk;

  // event counts and shortest data hold after a clock fall
  always @(posedge clk) begin
    n_st <= n_st + start_seen;
    n_sp <= n_sp + stop_seen;
    n_irq <= n_irq + cond_irq;
    n_col <= n_col + bus_collision;
    scl_q <= scl_w;
    oe_q <= sda_oe;
    fc <= (scl_q && !scl_w) ? 0 : fc + 1;
    if (sda_oe && !oe_q && fc < hmin[ctrl.data_hold_select])
      hmin[ctrl.data_hold_select] <= fc;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] dv, input logic ak);
    m.byte_io(dv, q);
    m.bit_io(ak, a);
  endtask : xfer

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    start_request = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    ctrl = '0;
    void'($urandom(32'h996646e4));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    chk({stat.bus_idle, rx_valid, scl_oe, sda_oe}, 4'h8);
    adr = 10'($urandom);
    ctrl.serial_port_enable = 1'b1;
    ctrl.data_hold_select = 1'b1;
    ctrl.slave_address_reg = adr;
    m.wt(4);
    m.start();
    xfer({adr[6:0], 1'b0}, 1'b1);
    chk(a, 1'b0);
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      exp_q.push_back(d);
      xfer(d, 1'b1);
      chk(a, 1'b0);
    end
    m.start();
    xfer({adr[6:0], 1'b0}, 1'b1);
    chk(a, 1'b0);
    m.stop();
    chk(n_st, 2);
    chk(n_sp, 1);
    chk(stat.bus_idle, 1'b1);
    chk(hmin[1] >= ibc_pkg::HOLD_LONG, 1'b1);
    chk({scl_o, sda_o}, 2'b00);
    while (exp_q.size() > 0) begin
      rx_ready = 1'($urandom);
      chk(rx_valid, 1'b1);
      chk(rx_data, exp_q[0]);
      @(negedge clk);
      if (rx_ready) void'(exp_q.pop_front());
    end
    rx_ready = 1'b0;
    chk(rx_valid, 1'b0);
    $display("test write done");
    d = 8'($urandom) | 8'h80;
    tx_data = d;
    tx_valid = 1'b1;
    m.start();
    xfer({adr[6:0], 1'b1}, 1'b1);
    chk(a, 1'b0);
    xfer(8'hff, 1'b0);
    chk(q, d);
    xfer(8'h00, 1'b1);
    chk(n_col, 1);
    m.stop();
    tx_valid = 1'b0;
    $display("test read done");
    m.sda_low = 1'b1;
    m.wt(8);
    m.sda_low = 1'b0;
    m.wt(8);
    chk(n_st, 4);
    chk(n_sp, 2);
    m.scl_low = 1'b1;
    m.wt(8);
    m.stop();
    chk(n_sp, 3);
    $display("test stop rule done");
    for (int k = 0; k < 4; k++) begin
      ctrl.mode = ibc_pkg::ibc_mode_e'(k);
      ctrl.start_irq_enable = 1'($urandom);
      ctrl.stop_irq_enable = 1'($urandom);
      irq0 = n_irq;
      m.start();
      m.stop();
      chk(n_irq - irq0, (k[1] | ctrl.start_irq_enable) +
                 (k[1] | ctrl.stop_irq_enable));
    end
    $display("test events done");
    ctrl.mode = ibc_pkg::MODE_S10;
    ctrl.data_hold_select = 1'b0;
    m.start();
    xfer({ibc_pkg::TEN_BIT_PREFIX, adr[9:8], 1'b0}, 1'b1);
    chk(a, 1'b0);
    xfer(adr[7:0], 1'b1);
    chk({a, stat.prior_match}, 2'b01);
    m.start();
    xfer({ibc_pkg::TEN_BIT_PREFIX, adr[9:8], 1'b1}, 1'b1);
    chk(a, 1'b0);
    fork
      begin
        m.wt(60);
        chk({tx_ready, scl_oe, stat.read_mode, stat.addressed}, 4'hf);
        tx_valid = 1'b1;
      end
    join_none
    xfer(8'hff, 1'b1);
    chk(q, d);
    m.stop();
    tx_valid = 1'b0;
    chk(stat.prior_match, 1'b0);
    chk(hmin[0] >= ibc_pkg::HOLD_SHORT &&
        hmin[0] < ibc_pkg::HOLD_LONG, 1'b1);
    $display("test ten bit done");
    ctrl.mode = ibc_pkg::MODE_S7;
    start_request = 1'b1;
    @(negedge clk);
    chk(sda_oe, 1'b1);
    start_request = 1'b0;
    ctrl.serial_port_enable = 1'b0;
    @(negedge clk);
    chk({scl_oe, sda_oe}, 2'b00);
    ctrl.serial_port_enable = 1'b1;
    m.wt(8);
    m.scl_low = 1'b1;
    m.wt(8);
    m.stop();
    m.scl_low = 1'b1;
    m.sda_low = 1'b1;
    m.wt(8);
    start_request = 1'b1;
    @(negedge clk);
    start_request = 1'b0;
    m.wt(4);
    chk(n_col, 2);
    m.sda_low = 1'b0;
    m.wt(8);
    m.scl_low = 1'b0;
    $display("test start request done");
    stop_test();
  end
endmodule : tb
